// file: src/ffl_report.sv
/*
 * Fault qualification and LIN frame reporting with an AXI4-Lite slave.
 * Assumes fault condition inputs are asynchronous levels, while
 * measurement, sample and LIN status inputs come from aclk logic.
 */
`timescale 1ns/1ps
`include "ffl_regs.svh"

// Summary of operation
// R01 - N-check flag after N consecutive checks
// R02 - Confirm within N to N+1 50 ms periods
// R03 - Average 16 samples, flag on mismatch
// R04 - One-time faults flag on first occurrence
// R05 - Under-range flags report floating bridge inputs in run mode
// R06 - Range fault: frames 1/2 bridge 0xFFF
// R07 - Range fault: frame 3 sensor error set
// R08 - One-time faults at bit ID minus one
module ffl_report
    import ffl_pkg::*;
#(
    parameter int DIAG_CYCLES = `FFL_CLK_HZ / 1000 * `FFL_DIAG_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`FFL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`FFL_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`FFL_RANGE_W-1:0] range_fault_raw,
    input wire logic [`FFL_ONE_TIME_W-1:0] one_time_raw,
    input wire logic [11:0] avg_sample,
    input wire logic avg_sample_valid,
    input wire logic [11:0] bridge_in,
    input wire logic [11:0] ext_temp_in,
    input wire logic [11:0] int_temp_in,
    input wire ffl_lin_err_t lin_err_in,
    output ffl_frame12_t frame12_out,
    output ffl_frame3_t frame3_out,
    output logic [31:0] fault_flags,
    output logic bridge_positive_floating,
    output logic bridge_negative_floating
);

    function automatic logic reg_sel(input logic [`FFL_ADDR_W-1:0] addr,
                                     input logic [`FFL_ADDR_W-1:0] off);
        reg_sel = (addr[`FFL_ADDR_W-1:2] == off[`FFL_ADDR_W-1:2]);
    endfunction

    // Diagnostic period divider
    logic [`FFL_DIAG_CNT_W-1:0] diag_cnt;
    logic tick;
    wire diag_wrap = (diag_cnt == `FFL_DIAG_CNT_W'(DIAG_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_cnt <= '0;
            tick <= 1'b0;
        end else begin
            diag_cnt <= diag_wrap ? '0 : diag_cnt + `FFL_DIAG_CNT_W'(1);
            tick <= diag_wrap; // R02
        end
    end

    // Fault inputs come from analog comparators, so two flops first
    logic [`FFL_RANGE_W-1:0] range_meta, range_sync;
    logic [`FFL_ONE_TIME_W-1:0] one_meta, one_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_meta <= '0;
            range_sync <= '0;
            one_meta <= '0;
            one_sync <= '0;
        end else begin
            range_meta <= range_fault_raw;
            range_sync <= range_meta;
            one_meta <= one_time_raw;
            one_sync <= one_meta;
        end
    end

    // Control registers
    logic [`FFL_N_W-1:0] repeat_n;
    logic run_mode;
    logic [11:0] expect_q;

    // Bridge input range faults, N-check policy
    logic [`FFL_RANGE_W-1:0] range_flag;
    wire range_any = |range_flag;

    generate
        for (genvar i = 0; i < `FFL_RANGE_W; i++) begin : g_range
            ffl_ncheck u_check (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .cond(range_sync[i]),
                .threshold(repeat_n),
                .flag(range_flag[i])
            ); // R01 R02
        end
    endgenerate

    // One-time faults are sticky; recovery is not handled here
    logic [`FFL_ONE_TIME_W-1:0] one_flags;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            one_flags <= '0;
        end else begin
            one_flags <= one_flags | one_sync; // R04
        end
    end

    // Sixteen-sample average; the sum cannot overflow 16 bits
    logic [15:0] avg_sum;
    logic [3:0] avg_cnt;
    logic [11:0] avg_value;
    logic avg_flag, avg_done;
    wire [15:0] next_sum = avg_sum + 16'(avg_sample);
    wire [11:0] next_avg = 12'(next_sum >> `FFL_AVG_SHIFT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            avg_sum <= '0;
            avg_cnt <= '0;
            avg_value <= '0;
            avg_flag <= 1'b0;
            avg_done <= 1'b0;
        end else begin
            avg_done <= 1'b0;
            if (avg_sample_valid) begin
                avg_cnt <= avg_cnt + 4'h1;
                avg_sum <= (avg_cnt == `FFL_AVG_LAST) ? '0 : next_sum;
                if (avg_cnt == `FFL_AVG_LAST) begin
                    avg_value <= next_avg; // R03
                    avg_flag <= (next_avg != expect_q); // R03
                    avg_done <= 1'b1;
                end
            end
        end
    end

    // Flag word: bit position is fault ID minus one, IDs 7 and 8 reserved
    wire [31:0] next_flags =
        (32'(range_flag) << `FFL_BIT_RANGE_LO) |
        (32'(avg_flag) << `FFL_BIT_AVG) |
        32'(one_flags); // R08

    // Frame fields
    wire ffl_frame12_t next_frame12 = '{
        bridge: range_any ? `FFL_FULL_SCALE : bridge_in,
        ext_temp: ext_temp_in,
        int_temp: int_temp_in,
        global_fault: !range_any && lin_err_in.global_fault,
        checksum_error: !range_any && lin_err_in.checksum_error,
        response_error: !range_any && lin_err_in.response_error,
        timeout: !range_any && lin_err_in.timeout
    }; // R06
    wire ffl_frame3_t next_frame3 = '{
        bridge: bridge_in,
        int_temp: int_temp_in,
        sensor_error: range_any || lin_err_in.sensor_error,
        response_error: !range_any && lin_err_in.response_error,
        checksum_error: !range_any && lin_err_in.checksum_error,
        bit_error: !range_any && lin_err_in.bit_error
    }; // R07

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_flags <= '0;
            frame12_out <= '0;
            frame3_out <= '0;
            bridge_positive_floating <= 1'b0;
            bridge_negative_floating <= 1'b0;
        end else begin
            fault_flags <= next_flags;
            frame12_out <= next_frame12; // R06
            frame3_out <= next_frame3; // R07
            bridge_positive_floating <=
                run_mode && range_flag[`FFL_BRIDGE_POSITIVE_INPUT_UNDER]; // R05
            bridge_negative_floating <=
                run_mode && range_flag[`FFL_BRIDGE_NEGATIVE_INPUT_UNDER]; // R05
        end
    end

    // AXI4-Lite write path: address and data may come in either order
    logic aw_held, w_held;
    logic [`FFL_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = reg_sel(aw_addr, `FFL_REG_CTRL);
    wire wr_expect = reg_sel(aw_addr, `FFL_REG_EXPECT);
    wire wr_hit = wr_ctrl || wr_expect ||
        reg_sel(aw_addr, `FFL_REG_FLAGS) ||
        reg_sel(aw_addr, `FFL_REG_AVERAGE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FFL_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `FFL_RESP_OKAY : `FFL_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Threshold stands in for the nonvolatile copy loaded at boot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            repeat_n <= `FFL_N_RESET;
            run_mode <= `FFL_RUN_RESET;
            expect_q <= `FFL_EXPECT_RESET;
        end else if (wr_fire) begin
            if (wr_ctrl && w_strb[0]) begin
                repeat_n <= w_data[`FFL_N_W-1:0];
                run_mode <= w_data[`FFL_CTRL_RUN_BIT];
            end
            if (wr_expect && w_strb[0]) begin
                expect_q[7:0] <= w_data[7:0];
            end
            if (wr_expect && w_strb[1]) begin
                expect_q[11:8] <= w_data[11:8];
            end
        end
    end

    // AXI4-Lite read path
    wire rd_ctrl = reg_sel(s_axi_araddr, `FFL_REG_CTRL);
    wire rd_flags = reg_sel(s_axi_araddr, `FFL_REG_FLAGS);
    wire rd_expect = reg_sel(s_axi_araddr, `FFL_REG_EXPECT);
    wire rd_avg = reg_sel(s_axi_araddr, `FFL_REG_AVERAGE);
    wire rd_hit = rd_ctrl || rd_flags || rd_expect || rd_avg;
    wire [31:0] rd_data =
        rd_ctrl ? 32'({run_mode, repeat_n}) :
        rd_flags ? fault_flags :
        rd_expect ? 32'(expect_q) :
        rd_avg ? 32'(avg_value) : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `FFL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `FFL_RESP_OKAY : `FFL_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Helper: ticks seen while the first range condition stands unbroken
    logic [`FFL_N_W-1:0] onset_ticks;
    wire [`FFL_N_W-1:0] n_eff = (repeat_n == '0) ? `FFL_N_W'(1) : repeat_n;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            onset_ticks <= '0;
        end else if (!range_sync[0]) begin
            onset_ticks <= '0;
        end else if (tick && onset_ticks != `FFL_N_MAX) begin
            onset_ticks <= onset_ticks + `FFL_N_W'(1);
        end
    end

    sequence s_range_on;
        range_any;
    endsequence

    sequence s_frame12_fault;
        frame12_out.bridge == `FFL_FULL_SCALE && !frame12_out.global_fault
        && !frame12_out.checksum_error && !frame12_out.response_error
        && !frame12_out.timeout && frame12_out.ext_temp == $past(ext_temp_in);
    endsequence

    sequence s_frame3_fault;
        frame3_out.sensor_error && !frame3_out.response_error
        && !frame3_out.checksum_error && !frame3_out.bit_error
        && frame3_out.bridge == $past(bridge_in);
    endsequence

    a_range_not_early: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(range_flag[0]) |-> onset_ticks >= n_eff) // R02
        else $error("Range fault confirmed before N periods");

    a_range_not_late: assert property (@(posedge aclk) disable iff (!aresetn)
        onset_ticks > n_eff |-> range_flag[0]) // R02
        else $error("Range fault not confirmed by N+1 periods");

    a_avg_compare: assert property (@(posedge aclk) disable iff (!aresetn)
        avg_done |-> avg_flag == (avg_value != $past(expect_q))) // R03
        else $error("Average flag disagrees with comparison");

    a_one_time_first: assert property (@(posedge aclk) disable iff (!aresetn)
        one_sync != '0 |=> (one_flags & $past(one_sync)) == $past(one_sync))
        // R04
        else $error("One-time fault not flagged on first occurrence");

    a_float_report: assert property (@(posedge aclk) disable iff (!aresetn)
        run_mode && range_flag[`FFL_BRIDGE_POSITIVE_INPUT_UNDER] |=> bridge_positive_floating)
        // R05
        else $error("Positive bridge input floating not reported");

    a_frame12_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        s_range_on |=> s_frame12_fault) // R06
        else $error("Frames one and two wrong during range fault");

    a_frame3_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        s_range_on |=> s_frame3_fault) // R07
        else $error("Frame three wrong during range fault");

    a_flag_layout: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_flags[`FFL_ONE_TIME_W-1:0] == $past(one_flags)
        && fault_flags[7:6] == 2'h0) // R08
        else $error("One-time flag layout wrong");

endmodule

// file: include/ffl_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of
 * the fault filter and LIN report block.
 * Assumes inclusion by bare name from design files that also import ffl_pkg.
 */
`ifndef FFL_REGS_SVH
`define FFL_REGS_SVH

`define FFL_ADDR_W 8
`define FFL_REG_CTRL 8'h00
`define FFL_REG_FLAGS 8'h04
`define FFL_REG_EXPECT 8'h08
`define FFL_REG_AVERAGE 8'h0C

`define FFL_RESP_OKAY 2'h0
`define FFL_RESP_SLVERR 2'h2

`define FFL_N_W 4
`define FFL_N_RESET 4'h3
`define FFL_N_MAX 4'hF
`define FFL_CTRL_RUN_BIT 4
`define FFL_RUN_RESET 1'h1
`define FFL_EXPECT_RESET 12'h000

`define FFL_FULL_SCALE 12'hFFF
`define FFL_AVG_LAST 4'hF
`define FFL_AVG_SHIFT 4

`define FFL_BIT_RANGE_LO 26
`define FFL_BIT_AVG 14
`define FFL_ONE_TIME_W 6
`define FFL_RANGE_W 4
`define FFL_BRIDGE_NEGATIVE_INPUT_UNDER 1
`define FFL_BRIDGE_POSITIVE_INPUT_UNDER 3

`define FFL_DIAG_MS 50
`define FFL_CLK_HZ 200000000
`define FFL_DIAG_CNT_W 24

`endif

// file: include/ffl_pkg.sv
/*
 * Types shared by the fault filter and LIN report block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ffl_pkg;

    typedef struct packed {
        logic [11:0] bridge;
        logic [11:0] ext_temp;
        logic [11:0] int_temp;
        logic global_fault;
        logic checksum_error;
        logic response_error;
        logic timeout;
    } ffl_frame12_t;

    typedef struct packed {
        logic [11:0] bridge;
        logic [11:0] int_temp;
        logic sensor_error;
        logic response_error;
        logic checksum_error;
        logic bit_error;
    } ffl_frame3_t;

    typedef struct packed {
        logic global_fault;
        logic checksum_error;
        logic response_error;
        logic timeout;
        logic sensor_error;
        logic bit_error;
    } ffl_lin_err_t;

endpackage

// file: src/ffl_ncheck.sv
/*
 * One N-consecutive-check fault qualifier.
 * Assumes tick is a one-cycle pulse per diagnostic period and cond is
 * already synchronised to aclk.
 */
`timescale 1ns/1ps
`include "ffl_regs.svh"

module ffl_ncheck
    import ffl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic cond,
    input wire logic [`FFL_N_W-1:0] threshold,
    output logic flag
);

    logic [`FFL_N_W-1:0] count;
    // Set when the condition lapses inside the current period; a check
    // counts only after a whole period present, so confirmation never
    // comes before N periods
    logic gap;
    wire whole = cond && !gap;
    wire [`FFL_N_W-1:0] thr_eff;
    wire [`FFL_N_W-1:0] next_count;

    // A threshold of zero would still need one whole check to flag; treat it as one
    assign thr_eff = (threshold == '0) ? `FFL_N_W'(1) : threshold;
    assign next_count = (count == `FFL_N_MAX) ? count : count + `FFL_N_W'(1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            flag <= 1'b0;
            gap <= 1'b1;
        end else if (tick) begin
            count <= whole ? next_count : '0; // R01
            flag <= whole && (next_count >= thr_eff); // R01
            gap <= 1'b0; // R02
        end else if (!cond) begin
            gap <= 1'b1; // R02
        end
    end

    a_ncheck_confirm: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && whole && (next_count >= thr_eff) |=> flag) // R01
        else $error("N-check flag not raised at threshold");

    a_ncheck_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !cond |=> !flag && count == '0) // R01
        else $error("N-check not restarted by clean check");

endmodule

// file: test/ffl_lin_master.sv
/*
 * Behavioural bus master node that polls the sensor response frames.
 * Assumes the frames are levels on aclk; poll is a one-cycle request.
 */
`timescale 1ns/1ps

module ffl_lin_master
    import ffl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic poll,
    input wire ffl_frame12_t frame12,
    input wire ffl_frame3_t frame3,
    output ffl_frame12_t got12,
    output ffl_frame3_t got3,
    output logic got_valid
);
    // Captures both frames in the same cycle, so the pair is never torn
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            got_valid <= 1'b0;
            got12 <= '0;
            got3 <= '0;
        end else begin
            got_valid <= poll;
            if (poll) begin
                got12 <= frame12;
                got3 <= frame3;
            end
        end
    end
endmodule

// file: test/testbench.sv
/*
 * Self-checking bench for the fault filter and frame report block.
 * Assumes a short diagnostic period so N-check runs stay brief.
 */
`timescale 1ns/1ps
`include "ffl_regs.svh"

module testbench
    import ffl_pkg::*;
;
    localparam int D = 20;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, avg_sample_valid, poll, got_valid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, bridge_positive_floating, bridge_negative_floating;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, fault_flags, flags;
    logic [3:0] s_axi_wstrb, range_fault_raw;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] one_time_raw;
    logic [11:0] avg_sample, bridge_in, ext_temp_in, int_temp_in, e, s;
    ffl_lin_err_t lin_err_in;
    ffl_frame12_t frame12_out, got12;
    ffl_frame3_t frame3_out, got3;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [67:0] fq[$];
    int n_errors, n_tests, n, cnt, sum, j;

    ffl_report #(.DIAG_CYCLES(D)) i_ffl_report (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .range_fault_raw(range_fault_raw), .one_time_raw(one_time_raw),
        .avg_sample(avg_sample), .avg_sample_valid(avg_sample_valid),
        .bridge_in(bridge_in), .ext_temp_in(ext_temp_in),
        .int_temp_in(int_temp_in), .lin_err_in(lin_err_in),
        .frame12_out(frame12_out), .frame3_out(frame3_out),
        .fault_flags(fault_flags),
        .bridge_positive_floating(bridge_positive_floating),
        .bridge_negative_floating(bridge_negative_floating));

    ffl_lin_master i_ffl_lin_master (.aclk(aclk), .aresetn(aresetn),
        .poll(poll), .frame12(frame12_out), .frame3(frame3_out),
        .got12(got12), .got3(got3), .got_valid(got_valid));

    always #2.5 aclk = ~aclk;

    task automatic check(input string name, input logic [67:0] seen,
                         input logic [67:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok |= s_axi_awready;
            w_ok |= s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Expected frame pair from the measurement inputs now applied
    task automatic frames(input logic flt);
        logic [39:0] f12;
        logic [27:0] f3;
        f12 = {flt ? 12'hFFF : bridge_in, ext_temp_in, int_temp_in,
               flt ? 4'h0 : {lin_err_in.global_fault,
               lin_err_in.checksum_error, lin_err_in.response_error,
               lin_err_in.timeout}};
        f3 = {bridge_in, int_temp_in, flt ? 4'h8 : {lin_err_in.sensor_error,
              lin_err_in.response_error, lin_err_in.checksum_error,
              lin_err_in.bit_error}};
        fq.push_back({f12, f3});
        @(posedge aclk);
        poll <= 1'b1;
        @(posedge aclk);
        poll <= 1'b0;
        @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            check("bresp", s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (got_valid && fq.size() > 0)
            check("frames", {got12, got3}, fq.pop_front());
    end

    // Whole run needs under two thousand cycles; this bound only cuts a hang
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        end_sim();
    end

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, avg_sample_valid, poll} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {range_fault_raw, one_time_raw, avg_sample, lin_err_in} = '0;
        {bridge_in, ext_temp_in, int_temp_in} = '0;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(76496));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`FFL_REG_CTRL, 32'h13, `FFL_RESP_OKAY);
        rd(`FFL_REG_EXPECT, 32'h0, `FFL_RESP_OKAY);
        rd(8'h10, 32'h0, `FFL_RESP_SLVERR);
        wr(8'h10, 32'hFFFF_FFFF, 4'hF, `FFL_RESP_SLVERR);
        wr(`FFL_REG_FLAGS, 32'hFFFF_FFFF, 4'hF, `FFL_RESP_OKAY);
        wr(`FFL_REG_CTRL, 32'h0, 4'h0, `FFL_RESP_OKAY);
        rd(`FFL_REG_FLAGS, 32'h0, `FFL_RESP_OKAY);
        rd(`FFL_REG_CTRL, 32'h13, `FFL_RESP_OKAY);
        @(posedge aclk);
        bridge_in <= 12'($urandom());
        ext_temp_in <= 12'($urandom());
        int_temp_in <= 12'($urandom());
        lin_err_in <= 6'($urandom());
        @(posedge aclk);
        frames(1'b0);
        $display("test registers and pass-through done");
        flags = 32'h0;
        for (int i = 5; i >= 0; i--) begin
            @(posedge aclk);
            one_time_raw <= 6'h01 << i;
            repeat (3) @(posedge aclk);
            one_time_raw <= 6'h00;
            flags[i] = 1'b1;
            repeat (3) @(posedge aclk);
            rd(`FFL_REG_FLAGS, flags, `FFL_RESP_OKAY);
        end
        $display("test one-time faults done");
        // Second pass runs with run mode off, so floating must stay low
        for (int k = 0; k < 8; k++) begin
            j = k % 4;
            n = $urandom_range(1, 4);
            wr(`FFL_REG_CTRL, (k < 4 ? 32'h10 : 32'h0) | n, 4'h1,
               `FFL_RESP_OKAY);
            @(posedge aclk);
            range_fault_raw <= 4'h1 << j;
            repeat (n * D) @(posedge aclk);
            check("early", fault_flags[26+j], 1'b0);
            cnt = n * D;
            while (fault_flags[26+j] !== 1'b1 && cnt < (n + 1) * D + 5) begin
                @(posedge aclk);
                cnt++;
            end
            check("late", fault_flags[26+j], 1'b1);
            repeat (2) @(posedge aclk);
            check("neg_float", bridge_negative_floating, j == 1 && k < 4);
            check("pos_float", bridge_positive_floating, j == 3 && k < 4);
            frames(1'b1);
            range_fault_raw <= 4'h0;
            repeat (D + 6) @(posedge aclk);
            check("clear", fault_flags[29:26], 4'h0);
            frames(1'b0);
        end
        $display("test range faults done");
        e = 12'($urandom());
        wr(`FFL_REG_EXPECT, {20'h0, e}, 4'h3, `FFL_RESP_OKAY);
        for (int t = 0; t < 2; t++) begin
            sum = 0;
            for (int i = 0; i < 16; i++) begin
                s = (t == 0) ? e : 12'($urandom());
                sum += s;
                @(posedge aclk);
                avg_sample <= s;
                avg_sample_valid <= 1'b1;
                @(posedge aclk);
                avg_sample_valid <= 1'b0;
            end
            repeat (4) @(posedge aclk);
            check("avg_flag", fault_flags[14], 12'(sum >> 4) != e);
            rd(`FFL_REG_AVERAGE, 32'(sum >> 4), `FFL_RESP_OKAY);
        end
        $display("test averaging done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`FFL_REG_FLAGS, 32'h0, `FFL_RESP_OKAY);
        $display("test second reset done");
        end_sim();
    end
endmodule
